// ---- hw/gpio_port_data.sv ----
// Purpose: Port data registers of three GPIO ports behind an AXI4-Lite slave.
// Assumes: Pin inputs are asynchronous; SPI and USB engines run on REF_CLK.
// Notes:   Reads return synchronised pin levels, so they trail the pins by two cycles.
//
// What this block does
// - Written data bits drive output-enabled pins.
// - Reads return live pin levels, not latch.
// - Port 0 uses bits 7, 4, 3, 1.
// - Port 0 pins 4, 3 feed external interrupts.
// - Port 1 bits 6..3 are SPI or GPIO.
// - Regulator pin active only after enable bit.
// - USB off: port 1 bits 1, 0 are GPIO.
// - USB on: pins 1, 0 are D- and D+.
// - Force state: data bits drive D-/D+ directly.
// - Port 2 implements bits 1, 0 only.
// - Pin drives only when output enable set, except forced D-/D+.
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/10ps
`default_nettype none
module gpio_port_data
  import gpio_data_pkg::*;
(
  input  wire logic              REF_CLK,
  input  wire logic              RSTN,
  input  wire logic [ADDR_W-1:0] AWADDR,
  input  wire logic              AWVALID,
  output var  logic              AWREADY,
  input  wire logic [DATA_W-1:0] WDATA,
  input  wire logic [3:0]        WSTRB,
  input  wire logic              WVALID,
  output var  logic              WREADY,
  output var  logic [1:0]        BRESP,
  output var  logic              BVALID,
  input  wire logic              BREADY,
  input  wire logic [ADDR_W-1:0] ARADDR,
  input  wire logic              ARVALID,
  output var  logic              ARREADY,
  output var  logic [DATA_W-1:0] RDATA,
  output var  logic [1:0]        RRESP,
  output var  logic              RVALID,
  input  wire logic              RREADY,
  input  wire logic [7:0]        P0_IN,
  output var  logic [7:0]        P0_OUT,
  output var  logic [7:0]        P0_OE,
  input  wire logic [7:0]        P1_IN,
  output var  logic [7:0]        P1_OUT,
  output var  logic [7:0]        P1_OE,
  input  wire logic [1:0]        P2_IN,
  output var  logic [1:0]        P2_OUT,
  output var  logic [1:0]        P2_OE,
  output var  logic              EXT_IRQ_ONE,
  output var  logic              EXT_IRQ_TWO,
  input  wire logic [3:0]        SPI_OUT,
  input  wire logic [3:0]        SPI_OE,
  output var  logic [3:0]        SPI_IN,
  input  wire logic [1:0]        USB_TX,
  input  wire logic              USB_TX_OE,
  output var  logic [1:0]        USB_RX,
  output var  logic              USB_ENABLE,
  output var  logic              USB_FORCE,
  output var  logic              REGULATOR_OUTPUT_PIN_EN
);

  // ==========================================================================
  // Address decode
  // Returns {hit, index}; a hit needs word alignment and a mapped index.
  function automatic logic [IDX_W:0] decode(input logic [ADDR_W-1:0] a);
    logic [IDX_W-1:0] idx;
    idx = a[ADDR_W-1:2];
    decode = {(a[1:0] == WORD_ALIGN) && (idx <= IDX_SPIUSE), idx};
  endfunction

  // ==========================================================================
  // Pin synchronisers
  logic [7:0] p0_sync;
  logic [7:0] p1_sync;
  logic [1:0] p2_sync;

  pin_sync2 #(.W(8)) u_sync_p0 (.clk(REF_CLK), .rst_n(RSTN), .async_in(P0_IN), .sync_out(p0_sync));
  pin_sync2 #(.W(8)) u_sync_p1 (.clk(REF_CLK), .rst_n(RSTN), .async_in(P1_IN), .sync_out(p1_sync));
  pin_sync2 #(.W(2)) u_sync_p2 (.clk(REF_CLK), .rst_n(RSTN), .async_in(P2_IN), .sync_out(p2_sync));

  // ==========================================================================
  // Write channel
  // Address and data are held independently so either may arrive first.
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [7:0]        w_data_reg;
  logic              w_lane_reg;
  logic              aw_full_reg;
  logic              w_full_reg;
  logic              wr_go;
  logic [IDX_W:0]    wr_dec;
  logic              wr_hit;
  logic [IDX_W-1:0]  wr_idx;

  assign wr_go  = aw_full_reg && w_full_reg && !BVALID;
  assign wr_dec = decode(aw_addr_reg);
  assign wr_hit = wr_dec[IDX_W];
  assign wr_idx = wr_dec[IDX_W-1:0];

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      aw_addr_reg <= '0;
      w_data_reg  <= BYTE_RESET;
      w_lane_reg  <= 1'b0;
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      AWREADY     <= 1'b1;
      WREADY      <= 1'b1;
      BVALID      <= 1'b0;
      BRESP       <= RESP_OKAY;
    end else begin
      if (AWVALID && AWREADY) begin
        aw_addr_reg <= AWADDR;
        aw_full_reg <= 1'b1;
        AWREADY     <= 1'b0;
      end
      if (WVALID && WREADY) begin
        w_data_reg <= WDATA[7:0];
        w_lane_reg <= WSTRB[0];
        w_full_reg <= 1'b1;
        WREADY     <= 1'b0;
      end
      if (wr_go) begin
        aw_full_reg <= 1'b0;
        w_full_reg  <= 1'b0;
        BVALID      <= 1'b1;
        BRESP       <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (BVALID && BREADY) begin
        BVALID  <= 1'b0;
        AWREADY <= 1'b1;
        WREADY  <= 1'b1;
      end
    end
  end

  // A register is written only when the low byte lane is enabled.
  function automatic logic wr_sel(input logic [IDX_W-1:0] target, input logic go, input logic hit,
                                  input logic [IDX_W-1:0] idx, input logic lane);
    wr_sel = go && hit && lane && (idx == target);
  endfunction

  // ==========================================================================
  // Port data latches
  logic [7:0] p0_latch_reg;
  logic [7:0] p1_latch_reg;
  logic [7:0] p2_latch_reg;

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      p0_latch_reg <= BYTE_RESET;
      p1_latch_reg <= BYTE_RESET;
      p2_latch_reg <= BYTE_RESET;
    end else begin
      if (wr_sel(IDX_PORT0, wr_go, wr_hit, wr_idx, w_lane_reg)) begin
        p0_latch_reg <= w_data_reg & PORT0_MASK;
      end
      if (wr_sel(IDX_PORT1, wr_go, wr_hit, wr_idx, w_lane_reg)) begin
        p1_latch_reg <= w_data_reg & PORT1_MASK;
      end
      if (wr_sel(IDX_PORT2, wr_go, wr_hit, wr_idx, w_lane_reg)) begin
        p2_latch_reg <= w_data_reg & PORT2_MASK;
      end
    end
  end

  // ==========================================================================
  // Output enables and shared-function controls
  logic [7:0] p0_oe_reg;
  logic [7:0] p1_oe_reg;
  logic [7:0] p2_oe_reg;
  logic [7:0] regctl_reg;
  logic [7:0] usbctl_reg;
  logic [7:0] usbxcvr_reg;
  logic [7:0] spiuse_reg;

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      p0_oe_reg <= BYTE_RESET;
      p1_oe_reg <= BYTE_RESET;
      p2_oe_reg <= BYTE_RESET;
    end else begin
      if (wr_sel(IDX_OE0, wr_go, wr_hit, wr_idx, w_lane_reg)) begin
        p0_oe_reg <= w_data_reg & PORT0_MASK;
      end
      if (wr_sel(IDX_OE1, wr_go, wr_hit, wr_idx, w_lane_reg)) begin
        p1_oe_reg <= w_data_reg & PORT1_MASK;
      end
      if (wr_sel(IDX_OE2, wr_go, wr_hit, wr_idx, w_lane_reg)) begin
        p2_oe_reg <= w_data_reg & PORT2_MASK;
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      regctl_reg  <= BYTE_RESET;
      usbctl_reg  <= BYTE_RESET;
      usbxcvr_reg <= BYTE_RESET;
      spiuse_reg  <= BYTE_RESET;
    end else begin
      if (wr_sel(IDX_REGCTL, wr_go, wr_hit, wr_idx, w_lane_reg)) begin
        regctl_reg <= {7'h00, w_data_reg[REG_EN_BIT]};
      end
      if (wr_sel(IDX_USBCTL, wr_go, wr_hit, wr_idx, w_lane_reg)) begin
        usbctl_reg <= {w_data_reg[USB_EN_BIT], 7'h00};
      end
      if (wr_sel(IDX_USBXCVR, wr_go, wr_hit, wr_idx, w_lane_reg)) begin
        usbxcvr_reg <= {7'h00, w_data_reg[FORCE_BIT]};
      end
      if (wr_sel(IDX_SPIUSE, wr_go, wr_hit, wr_idx, w_lane_reg)) begin
        spiuse_reg <= w_data_reg & SPI_MASK;
      end
    end
  end

  // ==========================================================================
  // Pin multiplexing for port 1
  logic       usb_en;
  logic       usb_force;
  logic [7:0] p1_alt_out;
  logic [7:0] p1_alt_oe;
  logic [7:0] p1_alt_sel;
  logic [7:0] p1_pin_out;
  logic [7:0] p1_pin_oe;

  assign usb_en    = usbctl_reg[USB_EN_BIT];
  assign usb_force = usbxcvr_reg[FORCE_BIT];

  // The regulator owns its pin once enabled, so the GPIO driver lets go of it.
  always_comb begin
    p1_alt_out = 8'h00;
    p1_alt_oe  = 8'h00;
    p1_alt_sel = spiuse_reg & SPI_MASK;
    p1_alt_out[SPI_HI:SPI_LO] = SPI_OUT;
    p1_alt_oe[SPI_HI:SPI_LO]  = SPI_OE;
    p1_alt_sel[REGULATOR_OUTPUT_PIN_PIN]      = regctl_reg[REG_EN_BIT];
    p1_alt_sel[USB_DM_PIN]    = usb_en;
    p1_alt_sel[USB_DP_PIN]    = usb_en;
    if (usb_force) begin
      p1_alt_out[USB_DM_PIN] = p1_latch_reg[USB_DM_PIN];
      p1_alt_out[USB_DP_PIN] = p1_latch_reg[USB_DP_PIN];
      p1_alt_oe[USB_DM_PIN]  = 1'b1;
      p1_alt_oe[USB_DP_PIN]  = 1'b1;
    end else begin
      p1_alt_out[USB_DM_PIN] = USB_TX[1];
      p1_alt_out[USB_DP_PIN] = USB_TX[0];
      p1_alt_oe[USB_DM_PIN]  = USB_TX_OE;
      p1_alt_oe[USB_DP_PIN]  = USB_TX_OE;
    end
  end

  pin_select u_p1_select (
    .gpio_out (p1_latch_reg),
    .gpio_oe  (p1_oe_reg),
    .alt_out  (p1_alt_out),
    .alt_oe   (p1_alt_oe),
    .alt_sel  (p1_alt_sel),
    .pin_out  (p1_pin_out),
    .pin_oe   (p1_pin_oe)
  );

  // ==========================================================================
  // Pin and side-band outputs
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      P0_OUT <= BYTE_RESET;
      P0_OE  <= BYTE_RESET;
      P1_OUT <= BYTE_RESET;
      P1_OE  <= BYTE_RESET;
      P2_OUT <= 2'h0;
      P2_OE  <= 2'h0;
    end else begin
      P0_OUT <= p0_latch_reg;
      P0_OE  <= p0_oe_reg;
      P1_OUT <= p1_pin_out;
      P1_OE  <= p1_pin_oe;
      P2_OUT <= p2_latch_reg[1:0];
      P2_OE  <= p2_oe_reg[1:0];
    end
  end

  // Interrupt and engine inputs see the synchronised pin, so a driven output also triggers them.
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      EXT_IRQ_ONE <= 1'b0;
      EXT_IRQ_TWO <= 1'b0;
      SPI_IN      <= 4'h0;
      USB_RX      <= 2'h0;
      USB_ENABLE  <= 1'b0;
      USB_FORCE   <= 1'b0;
      REGULATOR_OUTPUT_PIN_EN     <= 1'b0;
    end else begin
      EXT_IRQ_ONE <= p0_sync[IRQ_ONE_PIN];
      EXT_IRQ_TWO <= p0_sync[IRQ_TWO_PIN];
      SPI_IN      <= p1_sync[SPI_HI:SPI_LO];
      USB_RX      <= {p1_sync[USB_DM_PIN], p1_sync[USB_DP_PIN]};
      USB_ENABLE  <= usb_en;
      USB_FORCE   <= usb_force;
      REGULATOR_OUTPUT_PIN_EN     <= regctl_reg[REG_EN_BIT];
    end
  end

  // ==========================================================================
  // Read channel
  logic [IDX_W:0] rd_dec;
  logic [7:0]     rd_byte;

  assign rd_dec = decode(ARADDR);

  always_comb begin
    unique case (rd_dec[IDX_W-1:0])
      IDX_PORT0:   rd_byte = p0_sync & PORT0_MASK;
      IDX_PORT1:   rd_byte = p1_sync & PORT1_MASK;
      IDX_PORT2:   rd_byte = {6'h00, p2_sync} & PORT2_MASK;
      IDX_OE0:     rd_byte = p0_oe_reg;
      IDX_OE1:     rd_byte = p1_oe_reg;
      IDX_OE2:     rd_byte = p2_oe_reg;
      IDX_REGCTL:  rd_byte = regctl_reg;
      IDX_USBCTL:  rd_byte = usbctl_reg;
      IDX_USBXCVR: rd_byte = usbxcvr_reg;
      IDX_SPIUSE:  rd_byte = spiuse_reg;
      default:     rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ARREADY <= 1'b1;
      RVALID  <= 1'b0;
      RDATA   <= '0;
      RRESP   <= RESP_OKAY;
    end else if (ARVALID && ARREADY) begin
      ARREADY <= 1'b0;
      RVALID  <= 1'b1;
      RDATA   <= rd_dec[IDX_W] ? {24'h000000, rd_byte} : '0;
      RRESP   <= rd_dec[IDX_W] ? RESP_OKAY : RESP_SLVERR;
    end else if (RVALID && RREADY) begin
      ARREADY <= 1'b1;
      RVALID  <= 1'b0;
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);

  sequence s_p0_write;
    wr_go && wr_hit && w_lane_reg && (wr_idx == IDX_PORT0);
  endsequence

  sequence s_p0_read;
    ARVALID && ARREADY && rd_dec[IDX_W] && (rd_dec[IDX_W-1:0] == IDX_PORT0);
  endsequence

  a_latch_to_pin: assert property (s_p0_write |=> ##1 P0_OUT == ($past(w_data_reg, 2) & PORT0_MASK))
    else $error("Port 0 pin level does not follow written data.");
  a_read_live_pins: assert property (s_p0_read |=> RVALID && RDATA[7:0] == ($past(p0_sync) & PORT0_MASK))
    else $error("Port 0 read does not return pin levels.");
  a_reserved_zero: assert property ((p0_latch_reg & ~PORT0_MASK) == 8'h00 && p2_latch_reg[7:2] == 6'h00)
    else $error("Reserved latch bit became set.");
  a_irq_pin_follow: assert property (EXT_IRQ_ONE == $past(P0_IN[IRQ_ONE_PIN], 3))
    else $error("External interrupt line does not follow its pin.");
  a_spi_route: assert property (spiuse_reg[SPI_LO] |=> P1_OUT[SPI_LO] == $past(SPI_OUT[0]))
    else $error("SPI function does not own its pin.");
  a_regulator_output_pin_gate: assert property (!regctl_reg[REG_EN_BIT] |=> !REGULATOR_OUTPUT_PIN_EN)
    else $error("Regulator enabled without its control bit.");
  a_usb_off_gpio: assert property (!usb_en |=> P1_OE[1:0] == $past(p1_oe_reg[1:0]))
    else $error("USB pins not under GPIO control while USB is off.");
  a_usb_handover: assert property (usb_en && !usb_force |=> P1_OE[1:0] == {2{$past(USB_TX_OE)}})
    else $error("USB transceiver does not own D- and D+.");
  a_usb_force: assert property (usb_en && usb_force |=> P1_OE[1:0] == 2'h3 && P1_OUT[1:0] == $past(p1_latch_reg[1:0]))
    else $error("Forced USB levels do not follow data bits.");
  a_oe_gate: assert property ((P2_OE & ~$past(p2_oe_reg[1:0])) == 2'h0)
    else $error("Port 2 pin driven without output enable.");
  a_port2_read: assert property (ARVALID && ARREADY && rd_dec == {1'b1, IDX_PORT2} |=> RDATA[7:2] == 6'h00)
    else $error("Port 2 reserved bits read non-zero.");

endmodule // gpio_port_data
`default_nettype wire

// ---- hw/gpio_data_pkg.sv ----
// Purpose: Shared constants for the port data register block.
// Assumes: Register indices are scaled by four to form AXI4-Lite byte addresses.
// Notes:   Masks mark the implemented bits of each port.
package gpio_data_pkg;
  // ==========================================================================
  // Bus geometry
  localparam int          ADDR_W       = 8;
  localparam int          DATA_W       = 32;
  localparam int          IDX_W        = 6;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
  localparam logic [1:0]  WORD_ALIGN   = 2'h0;
  // ==========================================================================
  // Register indices (byte address is four times the index)
  localparam logic [IDX_W-1:0] IDX_PORT0   = 6'h00;
  localparam logic [IDX_W-1:0] IDX_PORT1   = 6'h01;
  localparam logic [IDX_W-1:0] IDX_PORT2   = 6'h02;
  localparam logic [IDX_W-1:0] IDX_OE0     = 6'h03;
  localparam logic [IDX_W-1:0] IDX_OE1     = 6'h04;
  localparam logic [IDX_W-1:0] IDX_OE2     = 6'h05;
  localparam logic [IDX_W-1:0] IDX_REGCTL  = 6'h06;
  localparam logic [IDX_W-1:0] IDX_USBCTL  = 6'h07;
  localparam logic [IDX_W-1:0] IDX_USBXCVR = 6'h08;
  localparam logic [IDX_W-1:0] IDX_SPIUSE  = 6'h09;
  // ==========================================================================
  // Field layout and reset values
  localparam logic [7:0] PORT0_MASK   = 8'h9A;
  localparam logic [7:0] PORT1_MASK   = 8'hFF;
  localparam logic [7:0] PORT2_MASK   = 8'h03;
  localparam logic [7:0] SPI_MASK     = 8'h78;
  localparam logic [7:0] BYTE_RESET   = 8'h00;
  localparam int         REG_EN_BIT   = 0;
  localparam int         USB_EN_BIT   = 7;
  localparam int         FORCE_BIT    = 0;
  localparam int         REGULATOR_OUTPUT_PIN_PIN     = 2;
  localparam int         IRQ_ONE_PIN  = 3;
  localparam int         IRQ_TWO_PIN  = 4;
  localparam int         SPI_LO       = 3;
  localparam int         SPI_HI       = 6;
  localparam int         USB_DM_PIN   = 1;
  localparam int         USB_DP_PIN   = 0;
endpackage

// ---- hw/pin_sync2.sv ----
// Purpose: Two-flop synchroniser for a group of pin levels.
// Assumes: Inputs are asynchronous to REF_CLK.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/10ps
`default_nettype none
module pin_sync2 #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] async_in,
  output var  logic [W-1:0] sync_out
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule // pin_sync2
`default_nettype wire

// ---- hw/pin_select.sv ----
// Purpose: Chooses per pin between the port latch and an alternate function.
// Assumes: All inputs come from logic on REF_CLK.
// Notes:   Purely combinational; the caller registers the result.
`timescale 1ns/10ps
`default_nettype none
module pin_select (
  input  wire logic [7:0] gpio_out,
  input  wire logic [7:0] gpio_oe,
  input  wire logic [7:0] alt_out,
  input  wire logic [7:0] alt_oe,
  input  wire logic [7:0] alt_sel,
  output var  logic [7:0] pin_out,
  output var  logic [7:0] pin_oe
);
  always_comb begin
    pin_out = (alt_sel & alt_out) | (~alt_sel & gpio_out);
    pin_oe  = (alt_sel & alt_oe)  | (~alt_sel & gpio_oe);
  end
endmodule // pin_select
`default_nettype wire

// ---- bench/pin_board.sv ----
// Purpose: Board-side model of the port pins and what is wired to them.
// Assumes: The bench sets the level that the outside world drives on each pin.
// Notes:   Where the block drives a pin, its output wins; otherwise the board level shows.
`timescale 1ns/10ps
`default_nettype none
module pin_board (
  input  wire logic [7:0] p0_out,
  input  wire logic [7:0] p0_oe,
  input  wire logic [7:0] p1_out,
  input  wire logic [7:0] p1_oe,
  input  wire logic [1:0] p2_out,
  input  wire logic [1:0] p2_oe,
  input  wire logic [7:0] p0_ext,
  input  wire logic [7:0] p1_ext,
  input  wire logic [1:0] p2_ext,
  output var  logic [7:0] p0_in,
  output var  logic [7:0] p1_in,
  output var  logic [1:0] p2_in
);
  // ==========================================================================
  // Pin resolution
  // An enabled output overrides the board level, so no contention is modelled.
  assign p0_in = (p0_oe & p0_out) | (~p0_oe & p0_ext);
  assign p1_in = (p1_oe & p1_out) | (~p1_oe & p1_ext);
  assign p2_in = (p2_oe & p2_out) | (~p2_oe & p2_ext);
endmodule // pin_board
`default_nettype wire

// ---- bench/test_gpio_port_data.sv ----
// Purpose: Self-checking bench for the port data register block.
// Assumes: Pin levels take a few cycles through the synchroniser before a read sees them.
// Notes:   Each scenario is a task that drives the bus and pins and judges the result.
`timescale 1ns/10ps
`default_nettype none
`define CHK(A, E) begin total_checks++; if ((A) !== (E)) begin fail_count++; \
  $display("BAD t=%0t got %h exp %h", $time, (A), (E)); end end
module test_gpio_port_data
  import gpio_data_pkg::*;
;
  logic              REF_CLK = 1'b0;
  logic              RSTN = 1'b0;
  logic [ADDR_W-1:0] AWADDR = '0;
  logic [ADDR_W-1:0] ARADDR = '0;
  logic [DATA_W-1:0] WDATA = '0;
  logic [DATA_W-1:0] RDATA;
  logic [3:0]        WSTRB = 4'h0;
  logic              AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
  logic              AWREADY, WREADY, BVALID, ARREADY, RVALID;
  logic [1:0]        BRESP, RRESP;
  logic [7:0]        P0_IN, P0_OUT, P0_OE, P1_IN, P1_OUT, P1_OE;
  logic [1:0]        P2_IN, P2_OUT, P2_OE, USB_RX;
  logic [3:0]        SPI_OUT = 4'h0, SPI_OE = 4'h0, SPI_IN;
  logic [1:0]        USB_TX = 2'h0;
  logic              USB_TX_OE = 1'b0;
  logic              EXT_IRQ_ONE, EXT_IRQ_TWO, USB_ENABLE, USB_FORCE, REGULATOR_OUTPUT_PIN_EN;
  logic [7:0]        p0_ext = 8'h00, p1_ext = 8'h00;
  logic [1:0]        p2_ext = 2'h0;
  logic [7:0]        rd_val;
  logic [3:0]        wr_lanes = 4'hF;
  int                fail_count = 0;
  int                total_checks = 0;

  gpio_port_data dut (.REF_CLK, .RSTN, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY,
    .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY,
    .P0_IN, .P0_OUT, .P0_OE, .P1_IN, .P1_OUT, .P1_OE, .P2_IN, .P2_OUT, .P2_OE, .EXT_IRQ_ONE,
    .EXT_IRQ_TWO, .SPI_OUT, .SPI_OE, .SPI_IN, .USB_TX, .USB_TX_OE, .USB_RX, .USB_ENABLE, .USB_FORCE,
    .REGULATOR_OUTPUT_PIN_EN);
  pin_board board (.p0_out(P0_OUT), .p0_oe(P0_OE), .p1_out(P1_OUT), .p1_oe(P1_OE), .p2_out(P2_OUT),
    .p2_oe(P2_OE), .p0_ext(p0_ext), .p1_ext(p1_ext), .p2_ext(p2_ext), .p0_in(P0_IN), .p1_in(P1_IN),
    .p2_in(P2_IN));

  always #4 REF_CLK = ~REF_CLK;

  // ==========================================================================
  // Closing and bus tasks
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic timed_out();
    fail_count++;
    $display("BAD t=%0t got %h exp %h", $time, 1'b0, 1'b1);
    report_and_stop();
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge REF_CLK);
  endtask

  // Both write channels are offered together and each is dropped as soon as it is taken.
  task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] d, input logic [1:0] er);
    int n;
    @(posedge REF_CLK);
    AWADDR <= {idx, WORD_ALIGN};
    WDATA <= {24'h000000, d};
    WSTRB <= wr_lanes;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge REF_CLK);
      if (AWVALID && AWREADY) AWVALID <= 1'b0;
      if (WVALID && WREADY) WVALID <= 1'b0;
      if (BVALID) break;
    end
    if (n == 50) timed_out();
    BREADY <= 1'b0;
    `CHK(BRESP, er)
  endtask

  task automatic rd(input logic [IDX_W-1:0] idx, input logic [1:0] er, output logic [7:0] d);
    int n;
    @(posedge REF_CLK);
    ARADDR <= {idx, WORD_ALIGN};
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge REF_CLK);
      if (ARVALID && ARREADY) ARVALID <= 1'b0;
      if (RVALID) break;
    end
    if (n == 50) timed_out();
    RREADY <= 1'b0;
    d = RDATA[7:0];
    `CHK(RRESP, er)
    `CHK(RDATA[31:8], 24'h000000)
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    `CHK({P0_OE, P1_OE, P2_OE, P0_OUT}, 26'h0)
    rd(IDX_PORT0, RESP_OKAY, rd_val);
    `CHK(rd_val, BYTE_RESET)
    $display("test reset done");
  endtask

  task automatic t_port0();
    p0_ext <= 8'hFF;
    idle(5);
    rd(IDX_PORT0, RESP_OKAY, rd_val);
    `CHK(rd_val, 8'h9A)
    `CHK({EXT_IRQ_TWO, EXT_IRQ_ONE}, 2'h3)
    wr(IDX_PORT0, 8'hFF, RESP_OKAY);
    idle(3);
    `CHK(P0_OE, 8'h00)
    wr(IDX_OE0, 8'hFF, RESP_OKAY);
    p0_ext <= 8'h00;
    wr(IDX_PORT0, 8'h10, RESP_OKAY);
    idle(5);
    `CHK(P0_OUT, 8'h10)
    `CHK({EXT_IRQ_TWO, EXT_IRQ_ONE}, 2'h2)
    rd(IDX_PORT0, RESP_OKAY, rd_val);
    `CHK(rd_val, 8'h10)
    wr(IDX_OE0, 8'h00, RESP_OKAY);
    $display("test port0 done");
  endtask

  task automatic t_port2();
    wr(IDX_PORT2, 8'hFF, RESP_OKAY);
    wr(IDX_OE2, 8'hFF, RESP_OKAY);
    idle(5);
    `CHK({P2_OUT, P2_OE}, 4'hF)
    rd(IDX_PORT2, RESP_OKAY, rd_val);
    `CHK(rd_val, 8'h03)
    $display("test port2 done");
  endtask

  task automatic t_port1();
    p1_ext <= 8'h5A;
    wr(IDX_PORT1, 8'hF0, RESP_OKAY);
    idle(5);
    `CHK(P1_OUT, 8'hF0)
    rd(IDX_PORT1, RESP_OKAY, rd_val);
    `CHK(rd_val, 8'h5A)
    wr(IDX_OE1, 8'hFF, RESP_OKAY);
    wr(IDX_SPIUSE, SPI_MASK, RESP_OKAY);
    SPI_OUT <= 4'h5;
    SPI_OE <= 4'hF;
    idle(5);
    `CHK(P1_OUT[SPI_HI:SPI_LO], 4'h5)
    `CHK(SPI_IN, 4'h5)
    wr(IDX_SPIUSE, 8'h00, RESP_OKAY);
    idle(3);
    `CHK(P1_OUT[SPI_HI:SPI_LO], 4'hE)
    `CHK({REGULATOR_OUTPUT_PIN_EN, P1_OE[REGULATOR_OUTPUT_PIN_PIN]}, 2'h1)
    wr(IDX_REGCTL, 8'h01, RESP_OKAY);
    idle(3);
    `CHK({REGULATOR_OUTPUT_PIN_EN, P1_OE[REGULATOR_OUTPUT_PIN_PIN]}, 2'h2)
    wr(IDX_REGCTL, 8'h00, RESP_OKAY);
    $display("test port1 done");
  endtask

  task automatic t_usb();
    `CHK({P1_OUT[1:0], P1_OE[1:0]}, 4'h3)
    wr(IDX_USBCTL, 8'h80, RESP_OKAY);
    USB_TX <= 2'h1;
    USB_TX_OE <= 1'b1;
    idle(5);
    `CHK({USB_ENABLE, P1_OUT[1:0], USB_RX}, 5'h15)
    wr(IDX_USBXCVR, 8'h01, RESP_OKAY);
    wr(IDX_PORT1, 8'hF2, RESP_OKAY);
    idle(5);
    `CHK({USB_FORCE, P1_OUT[1:0], P1_OE[1:0], USB_RX}, 7'h6E)
    wr(IDX_USBCTL, 8'h00, RESP_OKAY);
    wr(IDX_USBXCVR, 8'h00, RESP_OKAY);
    idle(3);
    `CHK({USB_ENABLE, USB_FORCE, P1_OUT[1:0]}, 4'h2)
    $display("test usb done");
  endtask

  task automatic t_unmapped();
    wr(6'h3F, 8'hFF, RESP_SLVERR);
    rd(6'h3F, RESP_SLVERR, rd_val);
    `CHK(rd_val, 8'h00)
    // With the low byte lane off the write is answered but must leave the latch alone.
    wr_lanes <= 4'hE;
    wr(IDX_PORT0, 8'h81, RESP_OKAY);
    wr_lanes <= 4'hF;
    idle(3);
    `CHK(P0_OUT, 8'h10)
    $display("test unmapped done");
  endtask

  // A reset in mid-run must clear latches that hold written values.
  task automatic t_midreset();
    RSTN <= 1'b0;
    idle(2);
    RSTN <= 1'b1;
    idle(1);
    `CHK({P1_OUT, P1_OE, P2_OUT, P2_OE, REGULATOR_OUTPUT_PIN_EN}, 21'h0)
    rd(IDX_OE1, RESP_OKAY, rd_val);
    `CHK(rd_val, BYTE_RESET)
    $display("test midreset done");
  endtask

  initial begin
    repeat (12) @(posedge REF_CLK);
    RSTN <= 1'b1;
    @(posedge REF_CLK);
    t_reset();
    t_port0();
    t_port2();
    t_port1();
    t_usb();
    t_unmapped();
    t_midreset();
    report_and_stop();
  end
endmodule // test_gpio_port_data
`default_nettype wire
